// ---- hdl/plsr_cfg.svh ----
/*
 * Constants for the link-side status and receive framer: codes, field positions, counts.
 * Assumes inclusion by plsr_link.sv and the verification files; plsr_pkg.sv does not include it.
 */
`ifndef PLSR_CFG_SVH
`define PLSR_CFG_SVH
`define PLSR_CTL_IDLE 2'h0
`define PLSR_CTL_STATUS 2'h1
`define PLSR_CTL_RECV 2'h2
`define PLSR_CTL_GRANT 2'h3
`define PLSR_DATA_ON 8'hFF
`define PLSR_SPD_S100 8'h00
`define PLSR_SPD_S200 8'h40
`define PLSR_SPD_S400 8'h50
`define PLSR_FLAG_CYCLES 4'h2
`define PLSR_REG_CYCLES 4'h8
`define PLSR_BIT_ARB_GAP 0
`define PLSR_BIT_SUB_GAP 1
`define PLSR_BIT_BUS_RESET 2
`define PLSR_BIT_INTERRUPT 3
`define PLSR_PHYID_ADDR 4'h0
`define PLSR_FIFO_DEPTH 8
`endif

// ---- hdl/plsr_pkg.sv ----
/*
 * Types for the link-side status and receive framer.
 * Assumes plsr_cfg.svh is available on the include path.
 */
package plsr_pkg;
   typedef logic [1:0] plsr_speed_type; // 0 = 100, 1 = 200, 2 = 400 class
   typedef enum logic [2:0] {
      PLSR_IDLE = 3'h0,
      PLSR_STAT = 3'h1,
      PLSR_RX_ON = 3'h3,
      PLSR_RX_SPD = 3'h2,
      PLSR_RX_DATA = 3'h6,
      PLSR_GRANT = 3'h7
   } plsr_state_type;
endpackage

// ---- hdl/plsr_link.sv ----
/*
 * Device end of the parallel interface toward the link controller: status transfers
 * and forwarding of received packets through an 8-entry FIFO.
 * Assumes the serial-bus core supplies prefix/null pulses and a byte stream whose
 * source, once a packet's speed code is out, delivers a byte every cycle.
 */
`include "plsr_cfg.svh"

module plsr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Async reset
   input wire logic [WIDTH-1:0] in_data, // Write word
   input wire logic in_valid, // Write request
   output logic in_ready, // Room available
   output logic [WIDTH-1:0] out_data, // Head word
   output logic out_valid, // Head present
   input wire logic out_ready // Pop
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, rd_reg;
   logic [AW:0] cnt_reg, cnt_next;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign out_data = mem[rd_reg];
   always_ff @(posedge core_clk) begin
      if (push) mem[wr_reg] <= in_data;
   end
   // Flags are flops so the source sees a clean ready
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wr_reg <= push ? ((wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1) : wr_reg;
         rd_reg <= pop ? ((rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1) : rd_reg;
         cnt_reg <= cnt_next;
         in_ready <= cnt_next != (AW + 1)'(DEPTH);
         out_valid <= cnt_next != '0;
      end
   end
endmodule // plsr_fifo

module plsr_link #(
   parameter int FIFO_DEPTH = `PLSR_FIFO_DEPTH
) (
   input wire logic core_clk, // 200 MHz interface clock
   input wire logic rst_n, // Async reset
   input wire logic rx_prefix, // Data-prefix seen, pulse
   input wire plsr_pkg::plsr_speed_type rx_speed, // Speed class with rx_prefix
   input wire logic rx_null, // Data-end with no data, pulse
   input wire logic [7:0] rx_data, // Packet byte
   input wire logic rx_last, // Final byte of packet
   input wire logic rx_valid, // Byte offered
   output logic rx_ready, // FIFO room
   input wire logic ev_arb_gap, // Arbitration reset gap seen
   input wire logic ev_sub_gap, // Subaction gap seen
   input wire logic ev_bus_reset, // Bus reset entered
   input wire logic ev_cfg_timeout, // Configuration timeout
   input wire logic ev_pwr_low, // Cable power too low
   input wire logic ev_state_timeout, // State timeout
   input wire logic ev_port_change, // Port status change
   input wire logic rd_req, // Register read request, pulse
   input wire logic [3:0] rd_addr, // Register number
   input wire logic [7:0] rd_data, // Register contents
   input wire logic selfid_done, // Self-ID complete, pulse
   input wire logic [7:0] phy_id_data, // Node address register
   input wire logic reset_pending, // Bus reset about to start
   output logic [1:0] control_pair_o, // Control pair drive
   output logic control_pair_oe, // Control pair enable
   output logic [7:0] data_o, // Data lines drive
   output logic data_oe, // Data lines enable
   output logic req_clear // Fair/priority request cleared
);
   import plsr_pkg::*;

   plsr_state_type st_reg, st_next;
   logic [3:0] flag_reg, flag_set, snap_reg;
   logic [15:0] shift_reg;
   logic [3:0] cnt_reg;
   logic with_reg, reg_pend, rx_pend, null_pend, last_out;
   logic [3:0] reg_addr;
   logic [7:0] reg_data;
   logic [7:0] spd_reg;
   logic [3:0] last_cnt;
   logic [8:0] head;
   logic head_valid;

   // Flag set wins over the clear at transfer start
   assign flag_set[`PLSR_BIT_ARB_GAP] = ev_arb_gap;
   assign flag_set[`PLSR_BIT_SUB_GAP] = ev_sub_gap;
   assign flag_set[`PLSR_BIT_BUS_RESET] = ev_bus_reset;
   assign flag_set[`PLSR_BIT_INTERRUPT] = ev_cfg_timeout | ev_pwr_low | ev_state_timeout
      | ev_port_change;

   wire stat_want = (flag_reg != 4'h0) | reg_pend;
   wire start_stat = (st_reg == PLSR_IDLE) & ~rx_pend & ~rx_prefix & stat_want;
   wire rx_go = rx_pend | rx_prefix;
   wire in_stat = st_reg == PLSR_STAT;
   wire stat_len_end = cnt_reg == (with_reg ? `PLSR_REG_CYCLES : `PLSR_FLAG_CYCLES) - 4'h1;
   wire abandon = in_stat & rx_go;
   wire stat_done = in_stat & ~rx_go & stat_len_end;
   wire reg_done = stat_done & with_reg;
   wire data_ready = last_cnt != 4'h0 | ~rx_ready;
   wire pop = head_valid & ((st_reg == PLSR_RX_SPD) | (st_reg == PLSR_RX_DATA & ~last_out));
   wire push = rx_valid & rx_ready;
   wire [3:0] restore = (abandon && cnt_reg == 4'h0) ? (snap_reg & 4'hC) : 4'h0;
   wire [7:0] spd_code = (rx_speed == 2'h2) ? `PLSR_SPD_S400 :
      (rx_speed == 2'h1) ? `PLSR_SPD_S200 : `PLSR_SPD_S100;

   plsr_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_data({rx_last, rx_data}),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .out_data(head),
      .out_valid(head_valid),
      .out_ready(pop)
   );

   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         PLSR_IDLE: begin
            if (rx_go) st_next = PLSR_RX_ON;
            else if (start_stat) st_next = PLSR_STAT;
         end
         PLSR_STAT: begin
            if (rx_go) st_next = PLSR_RX_ON;
            else if (stat_len_end) st_next = reset_pending ? PLSR_GRANT : PLSR_IDLE;
         end
         PLSR_RX_ON: begin
            if (null_pend) st_next = PLSR_IDLE;
            else if (data_ready) st_next = PLSR_RX_SPD;
         end
         PLSR_RX_SPD: st_next = PLSR_RX_DATA;
         PLSR_RX_DATA: begin
            if (last_out) st_next = PLSR_IDLE;
         end
         PLSR_GRANT: st_next = PLSR_IDLE;
      endcase
   end

   wire [1:0] ctl_next = (st_next == PLSR_STAT) ? `PLSR_CTL_STATUS :
      (st_next == PLSR_GRANT) ? `PLSR_CTL_GRANT :
      (st_next == PLSR_IDLE) ? `PLSR_CTL_IDLE : `PLSR_CTL_RECV;
   wire [15:0] pkt = {reg_pend ? reg_data : 8'h00, reg_pend ? reg_addr : 4'h0,
      flag_reg};
   wire [7:0] d_next = (st_next == PLSR_STAT) ?
      {6'h00, start_stat ? pkt[1:0] : shift_reg[3:2]} :
      (st_next == PLSR_RX_ON) ? `PLSR_DATA_ON :
      (st_next == PLSR_RX_SPD) ? spd_reg :
      (st_next == PLSR_RX_DATA) ? (pop ? head[7:0] : data_o) : 8'h00;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_flag
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) flag_reg[gi] <= 1'b0;
            else if (flag_set[gi] | restore[gi]) flag_reg[gi] <= 1'b1;
            else if (start_stat) flag_reg[gi] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= PLSR_IDLE;
         control_pair_o <= `PLSR_CTL_IDLE;
         data_o <= 8'h00;
         control_pair_oe <= 1'b0;
         data_oe <= 1'b0;
         req_clear <= 1'b0;
      end else begin
         st_reg <= st_next;
         control_pair_o <= ctl_next;
         data_o <= d_next;
         control_pair_oe <= 1'b1;
         data_oe <= 1'b1;
         req_clear <= (ctl_next == `PLSR_CTL_RECV) && (control_pair_o != `PLSR_CTL_RECV);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= 16'h0000;
         snap_reg <= 4'h0;
         cnt_reg <= 4'h0;
         with_reg <= 1'b0;
      end else if (start_stat) begin
         shift_reg <= pkt;
         snap_reg <= flag_reg;
         cnt_reg <= 4'h0;
         with_reg <= reg_pend;
      end else if (in_stat) begin
         shift_reg <= {2'h0, shift_reg[15:2]};
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   // Read requests are ignored while one is still undelivered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_pend <= 1'b0;
         reg_addr <= 4'h0;
         reg_data <= 8'h00;
      end else if (reg_done) begin
         reg_pend <= 1'b0;
      end else if (!reg_pend && selfid_done) begin
         reg_pend <= 1'b1;
         reg_addr <= `PLSR_PHYID_ADDR;
         reg_data <= phy_id_data;
      end else if (!reg_pend && rd_req) begin
         reg_pend <= 1'b1;
         reg_addr <= rd_addr;
         reg_data <= rd_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_pend <= 1'b0;
         null_pend <= 1'b0;
         spd_reg <= `PLSR_SPD_S100;
         last_out <= 1'b0;
         last_cnt <= 4'h0;
      end else begin
         rx_pend <= rx_prefix & (st_next != PLSR_RX_ON);
         if (rx_prefix) spd_reg <= spd_code;
         if (st_reg == PLSR_RX_ON && null_pend) null_pend <= rx_null;
         else if (rx_null) null_pend <= 1'b1;
         if (st_next != PLSR_RX_DATA) last_out <= 1'b0;
         else if (pop) last_out <= head[8];
         last_cnt <= last_cnt + {3'h0, push & rx_last} - {3'h0, pop & head[8]};
      end
   end

   // Checks on the interface and on the internal state that drives it
   logic [3:0] stat_run;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) stat_run <= 4'h0;
      else if (control_pair_o == `PLSR_CTL_STATUS) stat_run <= stat_run + 4'h1;
      else stat_run <= 4'h0;
   end

   // Speed is the first non-data-on byte of a run; later FF bytes are plain data
   logic spd_gone;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) spd_gone <= 1'b0;
      else spd_gone <= (control_pair_o == `PLSR_CTL_RECV)
         & (spd_gone | (data_o != `PLSR_DATA_ON));
   end

   sequence s_rx_open;
      control_pair_o == `PLSR_CTL_RECV && $past(control_pair_o) != `PLSR_CTL_RECV;
   endsequence
   sequence s_speed_cycle;
      control_pair_o == `PLSR_CTL_RECV && data_o != `PLSR_DATA_ON && !spd_gone
         && $past(data_o) == `PLSR_DATA_ON && $past(control_pair_o) == `PLSR_CTL_RECV;
   endsequence

   a_status_after_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (control_pair_o == `PLSR_CTL_STATUS && $past(control_pair_o) != `PLSR_CTL_STATUS)
      |-> $past(control_pair_o) == `PLSR_CTL_IDLE) else $error("status without idle gap");
   a_status_len_ok: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(control_pair_o) == `PLSR_CTL_STATUS && control_pair_o != `PLSR_CTL_STATUS
      && control_pair_o != `PLSR_CTL_RECV) |-> ($past(stat_run) == 4'h1
      || $past(stat_run) == 4'h7)) else $error("status transfer length wrong");
   a_status_bits_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      control_pair_o == `PLSR_CTL_STATUS |-> data_o[7:2] == 6'h00)
      else $error("status drives upper data lines");
   a_abort_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
      (in_stat && rx_go) |=> control_pair_o == `PLSR_CTL_RECV)
      else $error("status not abandoned for receive");
   a_rx_opens_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_rx_open |-> data_o == `PLSR_DATA_ON && req_clear) else $error("receive start wrong");
   a_speed_then_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_speed_cycle |-> st_reg == PLSR_RX_SPD ##1 control_pair_o == `PLSR_CTL_RECV)
      else $error("speed code not followed by data");
   a_rx_ends_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(control_pair_o) == `PLSR_CTL_RECV && control_pair_o != `PLSR_CTL_RECV)
      |-> control_pair_o == `PLSR_CTL_IDLE) else $error("receive not ended by idle");
   a_null_no_speed: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_reg == PLSR_RX_ON && null_pend) |=> control_pair_o == `PLSR_CTL_IDLE)
      else $error("null packet not closed");
   a_grant_after_full: assert property (@(posedge core_clk) disable iff (!rst_n)
      control_pair_o == `PLSR_CTL_GRANT |-> $past(control_pair_o) == `PLSR_CTL_STATUS
      ##1 control_pair_o == `PLSR_CTL_IDLE) else $error("grant misplaced");
   a_reg_after_eight: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(reg_pend) |-> $past(stat_run) == 4'h7) else $error("register dropped early");
endmodule // plsr_link

// ---- verif/plsr_lc_model.sv ----
/*
 * Passive link-controller model: decodes status runs and receive runs on the control pair.
 * Assumes the device side drives the interface; everything is sampled on rising core_clk.
 */
`include "plsr_cfg.svh"
module plsr_lc_model (
   input wire logic core_clk, // Interface clock
   input wire logic rst_n, // Async reset
   input wire logic [1:0] control_pair, // Control pair seen
   input wire logic [7:0] data_in, // Data lines seen
   output logic [15:0] stat_word, // Last status run
   output int stat_bits, // Bits in status run
   output int n_stat, // Status runs ended
   output int n_cut, // Runs cut by receive
   output int n_grant, // Grant cycles
   output int n_pkt, // Receive runs ended
   output int n_on, // Runs opening data-on
   output int rx_bytes, // Payload bytes
   output logic [7:0] rx_spd, // Speed code taken
   output logic [7:0] last_byte // Final payload byte
);
   logic [1:0] prev;
   logic spd_seen;
   logic [15:0] shift;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev = `PLSR_CTL_IDLE;
         {stat_word, shift, rx_spd, last_byte, spd_seen} = '0;
         {stat_bits, n_stat, n_cut, n_grant, n_pkt, n_on, rx_bytes} = '0;
      end else begin
         if (control_pair == `PLSR_CTL_STATUS) begin
            if (prev != `PLSR_CTL_STATUS) begin
               shift = 16'h0000;
               stat_bits = 0;
            end
            // Guard keeps a merged run from indexing past the word
            if (stat_bits < 16) shift[stat_bits +: 2] = data_in[1:0];
            stat_bits = stat_bits + 2;
         end else if (prev == `PLSR_CTL_STATUS) begin
            stat_word = shift;
            n_stat++;
            if (control_pair == `PLSR_CTL_RECV) n_cut++;
         end
         if (control_pair == `PLSR_CTL_GRANT) n_grant++;
         if (control_pair == `PLSR_CTL_RECV) begin
            if (prev != `PLSR_CTL_RECV) begin
               spd_seen = 1'b0;
               rx_bytes = 0;
               rx_spd = `PLSR_DATA_ON;
               if (data_in == `PLSR_DATA_ON) n_on++;
            end else if (!spd_seen && data_in != `PLSR_DATA_ON) begin
               rx_spd = data_in;
               spd_seen = 1'b1;
            end else if (spd_seen) begin
               last_byte = data_in; // Speed code stays out of payload
               rx_bytes++;
            end
         end else if (prev == `PLSR_CTL_RECV) n_pkt++;
         prev = control_pair;
      end
   end
endmodule // plsr_lc_model

// ---- verif/testbench.sv ----
/*
 * Self-checking bench for plsr_link: status flags, register replies, receive, buffering.
 * Assumes plsr_lc_model on the interface; inputs change on the falling clock edge.
 */
`include "plsr_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_n = 1'b0;
   logic rx_prefix = 1'b0, rx_null = 1'b0, rx_last = 1'b0, rx_valid = 1'b0;
   plsr_pkg::plsr_speed_type rx_speed = 2'h0;
   logic [7:0] rx_data = 8'h00, rd_data = 8'h00, phy_id_data = 8'h00;
   logic [3:0] rd_addr = 4'h0;
   logic [6:0] ev = 7'h00;
   logic rd_req = 1'b0, selfid_done = 1'b0, reset_pending = 1'b0;
   logic rx_ready, control_pair_oe, data_oe, req_clear;
   logic [1:0] control_pair_o;
   logic [7:0] data_o, rx_spd, last_byte;
   logic [15:0] stat_word;
   int stat_bits, n_stat, n_cut, n_grant, n_pkt, n_on, rx_bytes;
   int failures = 0, n_checks = 0, n_clear = 0;
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) if (req_clear === 1'b1) n_clear <= n_clear + 1;
   plsr_link #(.FIFO_DEPTH(`PLSR_FIFO_DEPTH)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .rx_prefix(rx_prefix), .rx_speed(rx_speed),
      .rx_null(rx_null), .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .ev_arb_gap(ev[0]), .ev_sub_gap(ev[1]), .ev_bus_reset(ev[2]),
      .ev_cfg_timeout(ev[3]), .ev_pwr_low(ev[4]), .ev_state_timeout(ev[5]),
      .ev_port_change(ev[6]), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
      .selfid_done(selfid_done), .phy_id_data(phy_id_data), .reset_pending(reset_pending),
      .control_pair_o(control_pair_o), .control_pair_oe(control_pair_oe), .data_o(data_o),
      .data_oe(data_oe), .req_clear(req_clear));
   plsr_lc_model lc (
      .core_clk(core_clk), .rst_n(rst_n), .control_pair(control_pair_o), .data_in(data_o),
      .stat_word(stat_word), .stat_bits(stat_bits), .n_stat(n_stat), .n_cut(n_cut),
      .n_grant(n_grant), .n_pkt(n_pkt), .n_on(n_on), .rx_bytes(rx_bytes),
      .rx_spd(rx_spd), .last_byte(last_byte));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t %s: %h vs %h", $time, msg, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wait_ge(ref int cnt, input int target);
      for (int i = 0; i < 300 && cnt < target; i++) tick(1);
      check(16'(cnt >= target), 16'h1, "completion");
   endtask
   // Holds the byte until a cycle with room, then lets the taking edge pass
   task automatic push(input logic [7:0] b, input logic last);
      rx_valid = 1'b1;
      rx_data = b;
      rx_last = last;
      while (rx_ready !== 1'b1) tick(1);
      tick(1);
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_flags();
      int map[7] = '{0, 1, 2, 3, 3, 3, 3};
      for (int i = 0; i < 7; i++) begin
         ev[i] = 1'b1;
         tick(1);
         ev[i] = 1'b0;
         wait_ge(n_stat, i + 1);
         check(16'(stat_word[3:0]), 16'(1 << map[i]), "flag");
         check(16'(stat_bits), 16'h4, "flag length");
         tick(2);
      end
   endtask
   task automatic t_register();
      int base;
      base = n_stat;
      rd_req = 1'b1;
      rd_addr = 4'h5;
      rd_data = 8'hA5;
      ev[1] = 1'b1;
      tick(1);
      rd_req = 1'b0;
      ev[1] = 1'b0;
      wait_ge(n_stat, base + 1);
      check(stat_word, 16'hA552, "read reply");
      check(16'(stat_bits), 16'h10, "read length");
      selfid_done = 1'b1;
      phy_id_data = 8'h3C;
      tick(1);
      selfid_done = 1'b0;
      wait_ge(n_stat, base + 2);
      check(stat_word, {8'h3C, `PLSR_PHYID_ADDR, 4'h0}, "self-id reply");
      check(16'(stat_bits), 16'h10, "no merged run");
      tick(2);
   endtask
   task automatic t_receive();
      logic [7:0] code[3] = '{`PLSR_SPD_S100, `PLSR_SPD_S200, `PLSR_SPD_S400};
      for (int s = 0; s < 3; s++) begin
         rx_speed = 2'(s);
         rx_prefix = 1'b1;
         tick(1);
         rx_prefix = 1'b0;
         push(8'h10 + 8'(s), 1'b0);
         push(8'hE7, 1'b1);
         rx_valid = 1'b0;
         wait_ge(n_pkt, s + 1);
         check(16'(rx_spd), 16'(code[s]), "speed");
         check(16'(rx_bytes), 16'h2, "bytes");
         check(16'(last_byte), 16'hE7, "last byte");
         tick(2);
      end
      check(16'(n_on), 16'(n_pkt), "data-on first");
      check(16'(n_clear), 16'(n_pkt), "request clear");
   endtask
   task automatic t_null();
      int base;
      base = n_pkt;
      rx_prefix = 1'b1;
      tick(1);
      rx_prefix = 1'b0;
      tick(1);
      rx_null = 1'b1;
      tick(1);
      rx_null = 1'b0;
      wait_ge(n_pkt, base + 1);
      check(16'(rx_spd), 16'(`PLSR_DATA_ON), "null no speed");
      check(16'(rx_bytes), 16'h0, "null no data");
      tick(2);
   endtask
   task automatic t_interrupt();
      int base;
      base = n_stat;
      rd_req = 1'b1;
      rd_addr = 4'h9;
      rd_data = 8'h5A;
      ev[0] = 1'b1;
      tick(1);
      rd_req = 1'b0;
      ev[0] = 1'b0;
      for (int i = 0; i < 50 && control_pair_o !== `PLSR_CTL_STATUS; i++) tick(1);
      tick(1);
      rx_prefix = 1'b1;
      tick(1);
      rx_prefix = 1'b0;
      rx_null = 1'b1;
      tick(1);
      rx_null = 1'b0;
      wait_ge(n_stat, base + 2);
      check(16'(n_cut), 16'h1, "status to receive");
      check(stat_word, 16'h5A90, "retry word");
      check(16'(stat_bits), 16'h10, "retry length");
      tick(2);
   endtask
   task automatic t_grant();
      reset_pending = 1'b1;
      ev[0] = 1'b1;
      tick(1);
      ev[0] = 1'b0;
      wait_ge(n_grant, 1);
      check(stat_word, 16'h0001, "status before grant");
      reset_pending = 1'b0;
      tick(3);
   endtask
   task automatic t_fifo();
      int base;
      base = n_pkt;
      for (int i = 0; i < `PLSR_FIFO_DEPTH; i++) push(8'(i), 1'b0);
      rx_valid = 1'b0;
      check(16'(rx_ready), 16'h0, "buffer full");
      rx_prefix = 1'b1;
      tick(1);
      rx_prefix = 1'b0;
      push(8'h08, 1'b0);
      push(8'h09, 1'b1);
      rx_valid = 1'b0;
      wait_ge(n_pkt, base + 1);
      check(16'(rx_bytes), 16'(`PLSR_FIFO_DEPTH + 2), "all bytes");
      check(16'(last_byte), 16'h09, "order kept");
      check(16'(rx_ready), 16'h1, "buffer drained");
   endtask
   // Reset in mid-transfer must drop the pending reply and return to idle
   task automatic t_reset();
      rd_req = 1'b1;
      rd_addr = 4'h3;
      rd_data = 8'hC3;
      ev[3] = 1'b1;
      tick(1);
      rd_req = 1'b0;
      ev[3] = 1'b0;
      tick(2);
      check(16'(control_pair_o), 16'(`PLSR_CTL_STATUS), "status running");
      rst_n = 1'b0;
      tick(1);
      check(16'({control_pair_o, data_o}), 16'h0, "reset lines");
      check(16'({control_pair_oe, data_oe, req_clear, rx_ready}), 16'h0, "reset enables");
      rst_n = 1'b1;
      tick(12);
      check(16'(n_stat), 16'h0, "pending dropped by reset");
      check(16'({control_pair_oe, data_oe}), 16'h3, "drive after reset");
   endtask
   initial begin
      tick(3);
      check(16'({control_pair_o, control_pair_oe, data_oe}), 16'h0, "reset state");
      rst_n = 1'b1;
      tick(2);
      check(16'({control_pair_oe, data_oe}), 16'h3, "drive enable");
      t_flags();
      t_register();
      t_receive();
      t_null();
      t_interrupt();
      t_grant();
      t_fifo();
      t_reset();
      print_verdict();
   end
   initial begin
      #20000;
      failures++;
      print_verdict();
   end
endmodule // testbench
